/* File: rtl/rpsf_status.sv */
// rpsf_status: receive status flags of a four-lane 64b/66b pcs, with an
// apb register window and a maskable interrupt.
// assumes all event and level inputs come from the lane aligner, ber
// monitor and decoder on pclk, already timed to their metaframe.
//
// Functional notes
// RULE1: the marker-mismatch output pulses one cycle per lane marker error, back to back allowed.
// RULE2: the alignment-lost output is a level, 1 while alignment failed or was lost.
// RULE3: each of lanes 0 to 3 has its own one-cycle parity error pulse for a bad bip8.
// RULE4: the all-lanes-deskewed level is 1 only while every lane is aligned and deskewed.
// RULE5: while the all-lanes-deskewed level is 0 the receive side reports local fault.
// RULE6: the excess bit error rate level is 1 while the measured error rate is too high.
// RULE7: the link-ok level is 1 exactly when lanes are aligned and error rate is not high.
// RULE8: a 2-bit per-cycle increment counts cycles of 64b/66b code violations.
// RULE9: a one-bit qualifier marks cycles in which the code-violation increment is valid.
// RULE10: an 8-bit pattern mismatch increment is non-zero for one cycle per mismatch.
// RULE11: the pattern mismatch increment stays zero unless pattern checking is enabled.
// RULE12: a one-bit qualifier marks cycles in which the pattern mismatch increment is valid.
// RULE13: marker mismatch is only raised after markers were once seen on all lanes.
// RULE14: a 4-bit word-lock level has one bit per lane, 1 once that lane locked with a marker.
// RULE15: all status outputs are registered on pclk and are zero while reset is held.
// RULE16: the consumer accumulates increments only while their qualifiers are high.
`timescale 1ns/1ps
`include "rpsf_map.svh"

module rpsf_status
  import rpsf_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic [`RPSF_AW-1:0]    paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RPSF_DW-1:0]    pwdata,
  output logic      [`RPSF_DW-1:0]    prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [`RPSF_LANES-1:0] lane_lock_in,
  input  wire logic                   marker_err_in,
  input  wire logic                   align_err_in,
  input  wire logic [`RPSF_LANES-1:0] lane_bip_err_in,
  input  wire logic                   deskew_done_in,
  input  wire logic                   ber_high_in,
  input  wire logic [`RPSF_CV_W-1:0]  code_viol_in,
  input  wire logic [`RPSF_TP_W-1:0]  pattern_err_in,
  output logic      [`RPSF_LANES-1:0] lane_word_lock,
  output logic                        marker_mismatch,
  output logic                        alignment_lost,
  output logic      [`RPSF_LANES-1:0] lane_parity_err,
  output logic                        all_lanes_deskewed,
  output logic                        local_fault,
  output logic                        excess_bit_error_rate,
  output logic                        link_ok,
  output logic      [`RPSF_CV_W-1:0]  code_viol_inc,
  output logic                        code_viol_valid,
  output logic      [`RPSF_TP_W-1:0]  pattern_err_inc,
  output logic                        pattern_err_valid,
  output logic                        irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // exact address match on all address bits, used by read and write decode
  function automatic logic reg_hit(input logic [`RPSF_AW-1:0] a,
                                   input logic [`RPSF_AW-1:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  // any mapped offset
  function automatic logic reg_mapped(input logic [`RPSF_AW-1:0] a);
    reg_mapped = reg_hit(a, `RPSF_OFF_CTRL) || reg_hit(a, `RPSF_OFF_STAT) ||
                 reg_hit(a, `RPSF_OFF_ISTAT) || reg_hit(a, `RPSF_OFF_IMASK);
  endfunction : reg_mapped

  // ****************************************************************
  // state
  // ****************************************************************
  rpsf_state_t s_q;
  rpsf_state_t s_d;

  logic                  setup_ph;
  logic                  wr_done;
  logic [`RPSF_EV_W-1:0] ev;
  logic [`RPSF_EV_W-1:0] w1c;
  logic [`RPSF_DW-1:0]   stat_word;

  // setup phase loads read data; access phase completes with pready high
  assign setup_ph = psel && !penable;
  assign wr_done  = psel && penable && pwrite && s_q.pready;

  // live status word as software sees it
  always_comb begin
    stat_word = `RPSF_DATA_ZERO;
    stat_word[`RPSF_ST_LOCK +: `RPSF_LANES] = s_q.lock;
    stat_word[`RPSF_ST_DESK]  = s_q.desk;
    stat_word[`RPSF_ST_ALOST] = s_q.alost;
    stat_word[`RPSF_ST_BER]   = s_q.ber;
    stat_word[`RPSF_ST_OK]    = s_q.ok;
  end

  // ****************************************************************
  // next state
  // ****************************************************************

  // one image of the whole block; apb, flags and sticky bits together
  always_comb begin
    s_d = s_q;

    // levels follow their sources one cycle later
    s_d.lock  = lane_lock_in;                           // RULE14
    s_d.alost = align_err_in;                           // RULE2
    s_d.desk  = deskew_done_in;                         // RULE4
    s_d.fault = !deskew_done_in;                        // RULE5
    s_d.ber   = ber_high_in;                            // RULE6
    s_d.ok    = deskew_done_in && !ber_high_in;         // RULE7

    // markers seen once on every lane arms the mismatch pulse
    if (&lane_lock_in) begin
      s_d.seen_all = 1'b1;                              // RULE13
    end
    // pulse per error, no edge detect so back-to-back errors all show
    s_d.mm = marker_err_in && (s_q.seen_all || (&lane_lock_in)); // RULE1 RULE13

    // per-lane parity pulses, one cycle each
    s_d.perr = lane_bip_err_in;                         // RULE3

    // increments and their qualifiers
    s_d.cv     = code_viol_in;                          // RULE8
    s_d.cv_vld = 1'b1;                                  // RULE9
    s_d.tp     = s_q.tp_en ? pattern_err_in : '0;       // RULE10 RULE11
    s_d.tp_vld = s_q.tp_en;                             // RULE12

    // events into the sticky status
    ev = '0;
    ev[`RPSF_EV_MM]    = s_d.mm;
    ev[`RPSF_EV_ALOST] = align_err_in && !s_q.alost;
    ev[`RPSF_EV_PERR +: `RPSF_LANES] = lane_bip_err_in;
    ev[`RPSF_EV_BER]   = ber_high_in && !s_q.ber;
    ev[`RPSF_EV_CV]    = |code_viol_in;
    ev[`RPSF_EV_TP]    = |s_d.tp;

    // writes: control, mask, write-one-to-clear; a new event beats the clear
    w1c = '0;
    if (wr_done && reg_hit(paddr, `RPSF_OFF_CTRL)) begin
      s_d.tp_en = pwdata[`RPSF_CTRL_TPEN];
    end
    if (wr_done && reg_hit(paddr, `RPSF_OFF_IMASK)) begin
      s_d.imask = pwdata[`RPSF_EV_W-1:0];
    end
    if (wr_done && reg_hit(paddr, `RPSF_OFF_ISTAT)) begin
      w1c = pwdata[`RPSF_EV_W-1:0];
    end
    s_d.ist = (s_q.ist & ~w1c) | ev;
    s_d.irq = |(s_d.ist & s_d.imask);

    // apb: registered answer, one access cycle, pslverr on unmapped address
    s_d.pready  = setup_ph;
    s_d.pslverr = setup_ph && !reg_mapped(paddr);
    if (setup_ph) begin
      case (1'b1)
        reg_hit(paddr, `RPSF_OFF_CTRL): begin
          s_d.prdata = `RPSF_DATA_ZERO;
          s_d.prdata[`RPSF_CTRL_TPEN] = s_q.tp_en;
        end
        reg_hit(paddr, `RPSF_OFF_STAT): begin
          s_d.prdata = stat_word;
        end
        reg_hit(paddr, `RPSF_OFF_ISTAT): begin
          s_d.prdata = {{(`RPSF_DW-`RPSF_EV_W){1'b0}}, s_q.ist};
        end
        reg_hit(paddr, `RPSF_OFF_IMASK): begin
          s_d.prdata = {{(`RPSF_DW-`RPSF_EV_W){1'b0}}, s_q.imask};
        end
        default: begin
          s_d.prdata = `RPSF_DATA_ZERO;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************

  // async clear to all-zero; ce low freezes everything, bus included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;                                        // RULE15
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // outputs are the flops themselves
  assign lane_word_lock        = s_q.lock;
  assign marker_mismatch       = s_q.mm;
  assign alignment_lost        = s_q.alost;
  assign lane_parity_err       = s_q.perr;
  assign all_lanes_deskewed    = s_q.desk;
  assign local_fault           = s_q.fault;
  assign excess_bit_error_rate = s_q.ber;
  assign link_ok               = s_q.ok;
  assign code_viol_inc         = s_q.cv;
  assign code_viol_valid       = s_q.cv_vld;
  assign pattern_err_inc       = s_q.tp;
  assign pattern_err_valid     = s_q.tp_vld;
  assign irq                   = s_q.irq;
  assign prdata                = s_q.prdata;
  assign pready                = s_q.pready;
  assign pslverr               = s_q.pslverr;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mm_armed_a: assert property (marker_mismatch |-> s_q.seen_all) // RULE13
    else $error("marker mismatch raised before all lanes seen");

  mm_pulse_a: assert property ( // RULE1
    ce && marker_err_in && s_q.seen_all |=> marker_mismatch)
    else $error("marker error not reported next cycle");

  align_lost_a: assert property ( // RULE2
    ce |=> alignment_lost == $past(align_err_in))
    else $error("alignment lost does not follow its source");

  desk_fault_a: assert property ( // RULE4 RULE5
    presetn && ce |=> (all_lanes_deskewed == $past(deskew_done_in)) &&
           (local_fault != all_lanes_deskewed))
    else $error("deskew level and local fault disagree");

  ber_level_a: assert property ( // RULE6
    ce |=> excess_bit_error_rate == $past(ber_high_in))
    else $error("excess bit error rate does not follow source");

  link_ok_a: assert property ( // RULE7
    ce |=> link_ok == (all_lanes_deskewed && !excess_bit_error_rate))
    else $error("link ok wrong for deskew and ber state");

  cv_inc_a: assert property ( // RULE8 RULE9
    presetn && ce |=> code_viol_valid && (code_viol_inc == $past(code_viol_in)))
    else $error("code violation increment wrong");

  tp_off_a: assert property ( // RULE11
    ce && !s_q.tp_en |=> (pattern_err_inc == '0) && !pattern_err_valid)
    else $error("pattern increment active while checking is off");

  tp_inc_a: assert property ( // RULE10 RULE12
    ce && s_q.tp_en && (pattern_err_in != '0) |=>
      pattern_err_valid && (pattern_err_inc == $past(pattern_err_in)))
    else $error("pattern mismatch not reported");

  lock_level_a: assert property ( // RULE14
    ce |=> lane_word_lock == $past(lane_lock_in))
    else $error("word lock does not follow lanes");

  apb_answer_a: assert property (
    ce && setup_ph |=> pready)
    else $error("apb access not answered in one cycle");

  // the answer is a single-cycle pulse, so a master never sees it twice
  pready_pulse_a: assert property (
    ce && pready |=> !pready)
    else $error("pready held longer than one cycle");

  // an error answer always rides on pready and carries zero data
  slverr_ready_a: assert property (
    pslverr |-> pready)
    else $error("slave error without ready");

  slverr_data_a: assert property (
    pslverr |-> (prdata == `RPSF_DATA_ZERO))
    else $error("slave error with non-zero read data");

  // a write to a hole must not leak into control or mask
  unmapped_write_a: assert property (
    ce && wr_done && !reg_mapped(paddr) |=>
      (s_q.tp_en == $past(s_q.tp_en)) && (s_q.imask == $past(s_q.imask)))
    else $error("write to unmapped address changed a register");

  // the pattern check enable lands on the completing edge
  ctrl_write_a: assert property ( // RULE11
    ce && wr_done && reg_hit(paddr, `RPSF_OFF_CTRL) |=>
      s_q.tp_en == $past(pwdata[`RPSF_CTRL_TPEN]))
    else $error("pattern check enable not written");

  // ****************************************************************
  // status and interrupt checks
  // ****************************************************************

  // parity events must reach the sticky bits even when a clear collides
  perr_sticky_a: assert property ( // RULE3
    presetn && ce && (lane_bip_err_in != '0) |=>
      (s_q.ist[`RPSF_EV_PERR +: `RPSF_LANES] & $past(lane_bip_err_in)) ==
      $past(lane_bip_err_in))
    else $error("lane parity event lost from sticky status");

  // a rising high error rate is latched for software
  ber_sticky_a: assert property ( // RULE6
    presetn && ce && ber_high_in && !excess_bit_error_rate |=> s_q.ist[`RPSF_EV_BER])
    else $error("rising error rate not latched");

  // sticky bits only fall on an accepted write
  ist_hold_a: assert property (
    ce && !wr_done |=> (s_q.ist & $past(s_q.ist)) == $past(s_q.ist))
    else $error("sticky status bit fell without a write");

  // arming is one-way until the next reset
  arm_sticky_a: assert property ( // RULE13
    s_q.seen_all |=> s_q.seen_all)
    else $error("marker mismatch arming was lost");

  // without a marker error there is no pulse, so pulses never stretch
  mm_quiet_a: assert property ( // RULE1
    ce && !marker_err_in |=> !marker_mismatch)
    else $error("marker mismatch without a marker error");

  // the pattern qualifier tracks the enable of the previous edge
  tp_valid_a: assert property ( // RULE12
    presetn && ce |=> pattern_err_valid == $past(s_q.tp_en))
    else $error("pattern qualifier does not track the enable");

  // link ok can never stand while the lanes are not deskewed
  ok_needs_desk_a: assert property ( // RULE7
    link_ok |-> all_lanes_deskewed)
    else $error("link ok without deskew");

  // a low clock enable freezes every flop, bus answer included
  ce_freeze_a: assert property (
    presetn && !ce |=> $stable(s_q))
    else $error("state moved while clock enable was low");

  // one parity check per lane
  for (genvar i = 0; i < `RPSF_LANES; i++) begin : g_lane
    parity_lane_a: assert property ( // RULE3
      ce |=> lane_parity_err[i] == $past(lane_bip_err_in[i]))
      else $error("lane parity pulse wrong");
  end

endmodule : rpsf_status

/* File: shared/rpsf_map.svh */
// rpsf_map.svh: offsets, field positions, widths and reset values of the
// receive pcs lane status block; definitions only.
`ifndef RPSF_MAP_SVH
`define RPSF_MAP_SVH

// ****************************************************************
// widths
// ****************************************************************
`define RPSF_LANES      4
`define RPSF_CV_W       2
`define RPSF_TP_W       8
`define RPSF_AW         12
`define RPSF_DW         32
`define RPSF_EV_W       9

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define RPSF_OFF_CTRL   12'h000
`define RPSF_OFF_STAT   12'h004
`define RPSF_OFF_ISTAT  12'h008
`define RPSF_OFF_IMASK  12'h00C

// ****************************************************************
// field positions
// ****************************************************************
`define RPSF_CTRL_TPEN  0
`define RPSF_ST_LOCK    0
`define RPSF_ST_DESK    4
`define RPSF_ST_ALOST   5
`define RPSF_ST_BER     6
`define RPSF_ST_OK      7
`define RPSF_EV_MM      0
`define RPSF_EV_ALOST   1
`define RPSF_EV_PERR    2
`define RPSF_EV_BER     6
`define RPSF_EV_CV      7
`define RPSF_EV_TP      8

// ****************************************************************
// reset values
// ****************************************************************
`define RPSF_EV_RST     9'h000
`define RPSF_DATA_ZERO  32'h0000_0000

`endif

/* File: shared/rpsf_pkg.sv */
// rpsf_pkg: state type of the receive pcs lane status block.
// assumes rpsf_map.svh is on the include path.
`include "rpsf_map.svh"

package rpsf_pkg;

  // all state of the status block, registered as one word
  typedef struct packed {
    logic [`RPSF_LANES-1:0] lock;
    logic                   mm;
    logic                   alost;
    logic [`RPSF_LANES-1:0] perr;
    logic                   desk;
    logic                   fault;
    logic                   ber;
    logic                   ok;
    logic [`RPSF_CV_W-1:0]  cv;
    logic                   cv_vld;
    logic [`RPSF_TP_W-1:0]  tp;
    logic                   tp_vld;
    logic                   seen_all;
    logic                   tp_en;
    logic [`RPSF_EV_W-1:0]  ist;
    logic [`RPSF_EV_W-1:0]  imask;
    logic                   irq;
    logic [`RPSF_DW-1:0]    prdata;
    logic                   pready;
    logic                   pslverr;
  } rpsf_state_t;

endpackage : rpsf_pkg

/* File: sim/rpsf_far_model.sv */
// rpsf_far_model: lane aligner side stand-in driving the status sources from a
// scene code, plus the statistics consumer of the code-violation increment.
// assumes scene changes by nba just after a rising pclk edge.
`timescale 1ns/1ps

module rpsf_far_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] scene,
  input  wire logic [1:0] cv_inc,
  input  wire logic       cv_vld,
  output logic      [3:0] lock,
  output logic            mk_err,
  output logic            al_err,
  output logic      [3:0] bip,
  output logic            desk,
  output logic            ber,
  output logic      [1:0] cv,
  output logic      [7:0] tp,
  output logic      [7:0] cv_sum
);
  // sources follow the scene one edge later, like a registered aligner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lock, mk_err, al_err, bip, desk, ber, cv, tp} <= '0;
      cv_sum <= 8'h00;
    end else begin
      lock   <= (scene >= 4'h2) ? 4'hF : 4'h0;
      mk_err <= (scene == 4'h1) || (scene == 4'h2);
      al_err <= (scene == 4'h4);
      bip    <= (scene == 4'h5) ? 4'h5 : ((scene == 4'h6) ? 4'hA : 4'h0);
      desk   <= (scene >= 4'h7);
      ber    <= (scene == 4'h8);
      cv     <= (scene == 4'h9) ? 2'h3 : 2'h0;
      tp     <= (scene == 4'h9) ? 8'hA5 : 8'h00;
      // counts only qualified cycles, so stale increments never add up
      if (cv_vld) cv_sum <= cv_sum + 8'(cv_inc);
    end
  end
endmodule : rpsf_far_model

/* File: sim/test_rx_pcs_lane_status_flags.sv */
// test_rx_pcs_lane_status_flags: self-checking bench of the status block.
// assumes rpsf_map.svh on the include path; ce stays high except in the freeze check.
`timescale 1ns/1ps
`include "rpsf_map.svh"

module test_rx_pcs_lane_status_flags;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  scene, lock, bip, wl, pe;
  logic        mk, al, dk, br, mm, alost, desk, lf, ok, ber, cvv, tpv, irq, e;
  logic [1:0]  cv, cvi;
  logic [7:0]  tp, tpi, sum;
  int          errors, cmp_count, cyc;

  // ****************************************************************
  // clock, reset, instances
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  rpsf_far_model rpsf_far_model_inst (.pclk(pclk), .presetn(presetn), .scene(scene),
    .cv_inc(cvi), .cv_vld(cvv), .lock(lock), .mk_err(mk), .al_err(al), .bip(bip),
    .desk(dk), .ber(br), .cv(cv), .tp(tp), .cv_sum(sum));
  rpsf_status rpsf_status_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lane_lock_in(lock), .marker_err_in(mk),
    .align_err_in(al), .lane_bip_err_in(bip), .deskew_done_in(dk), .ber_high_in(br),
    .code_viol_in(cv), .pattern_err_in(tp), .lane_word_lock(wl), .marker_mismatch(mm),
    .alignment_lost(alost), .lane_parity_err(pe), .all_lanes_deskewed(desk),
    .local_fault(lf), .excess_bit_error_rate(ber), .link_ok(ok), .code_viol_inc(cvi),
    .code_viol_valid(cvv), .pattern_err_inc(tpi), .pattern_err_valid(tpv), .irq(irq));

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task put(input logic [3:0] sc);
    @(posedge pclk);
    scene <= sc;
  endtask : put
  // scene reaches the outputs two edges later: model edge, then block edge
  task wt;
    repeat (2) @(posedge pclk);
    #1;
  endtask : wt
  task nxt;
    @(posedge pclk);
    #1;
  endtask : nxt
  // apb transfer: setup, access held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_marker;
    put(4'h1); wt;
    chk("mm unarmed", 0, mm);
    put(4'h2); put(4'h2); put(4'h3); #1;
    chk("mm first", 1, mm);
    nxt; chk("mm second", 1, mm);
    nxt; chk("mm end", 0, mm);
    chk("word lock", 4'hF, wl);
    $display("test marker done");
  endtask : t_marker
  task t_lanes;
    ce <= 1'b0; // frozen flops must not take up the new source value
    put(4'h4); wt; chk("ce frozen", 0, alost);
    ce <= 1'b1;
    put(4'h4); wt; chk("alost set", 1, alost);
    put(4'h5); put(4'h6); put(4'h3); #1;
    chk("alost clr", 0, alost);
    chk("parity a", 4'h5, pe);
    nxt; chk("parity b", 4'hA, pe);
    nxt; chk("parity end", 4'h0, pe);
    chk("desk low", 0, desk);
    chk("fault on", 1, lf);
    chk("ok low", 0, ok);
    put(4'h7); wt; chk("ok desk", 3'h5, {desk, lf, ok});
    put(4'h8); wt; chk("ber ok", 3'h6, {desk, ber, ok});
    $display("test lanes done");
  endtask : t_lanes
  task t_incs;
    put(4'h9); put(4'h7); nxt;
    chk("cv inc", 2'h3, cvi);
    chk("cv vld", 1, cvv);
    chk("tp off", 9'h000, {tpv, tpi});
    nxt; chk("cv end", 2'h0, cvi);
    apb(1'b1, `RPSF_OFF_CTRL, 32'h0000_0001);
    put(4'h9); put(4'h7); nxt;
    chk("tp on", 9'h1A5, {tpv, tpi});
    nxt; chk("tp end", 8'h00, tpi);
    chk("cv sum", 8'h06, sum);
    $display("test incs done");
  endtask : t_incs
  task t_regs;
    apb(1'b0, `RPSF_OFF_CTRL, 0); chk("ctrl rst", 0, r);
    apb(1'b0, 12'h010, 0); chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
    nxt; chk("irq masked", 0, irq);
    apb(1'b1, `RPSF_OFF_IMASK, 32'h0000_0001); wt;
    chk("irq on", 1, irq);
    apb(1'b0, `RPSF_OFF_ISTAT, 0); chk("istat mm", 1, r[0]);
    apb(1'b1, `RPSF_OFF_ISTAT, 32'h0000_0001); wt;
    chk("irq off", 0, irq);
    put(4'h7); wt;
    apb(1'b0, `RPSF_OFF_STAT, 0); chk("status", 32'h0000_009F, r);
    $display("test regs done");
  endtask : t_regs

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, scene} = '0;
    ce = 1'b1;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    #12;
    chk("reset outs", 0, {wl, mm, alost, pe, desk, lf, ber, ok, cvi, cvv, tpi, tpv, irq,
      pready, pslverr});
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_marker();
    t_regs();
    t_lanes();
    t_incs();
    test_done();
  end
endmodule : test_rx_pcs_lane_status_flags
